// file: logic/ufs_status.sv
// UART channel status flags with queues, AXI4-Lite registers and interrupt
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none
module ufs_status
    import ufs_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // AXI4-Lite write address
    input wire logic [9:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [9:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Receiver side: character arriving from shift register logic
    input wire logic RX_CHAR_VALID,
    input wire logic [7:0] RX_CHAR_DATA,
    // Transmitter side: serializer pulls characters
    input wire logic TX_CHAR_TAKE,
    output logic TX_CHAR_VALID,
    output logic [7:0] TX_CHAR_DATA,
    // Status and interrupt
    output logic [7:0] CHANNEL_STATUS,
    output logic IRQ
);
    // ============================================================
    // Declarations
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_idx_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] ar_idx;
    logic tx_en_r;
    logic [7:0] tx_fill_threshold_r;
    logic [IRQ_W-1:0] int_stat_r;
    logic [IRQ_W-1:0] int_mask_r;
    logic [IRQ_W-1:0] int_event;
    logic hold_valid_r;
    logic [7:0] hold_data_r;
    logic rx_pop;
    logic rx_push;
    logic [7:0] rx_push_data;
    logic [7:0] rx_head;
    logic [CNT_W-1:0] rx_count;
    logic tx_push;
    logic tx_pop;
    logic [7:0] tx_head;
    logic [CNT_W-1:0] tx_count;
    logic rx_queue_full_flag_r;
    logic rx_char_waiting_r;
    logic tx_space_avail;
    logic tx_space_prev_r;
    logic rx_lost;
    logic [7:0] status_word;
    logic [31:0] rd_word;
    logic rd_ok;

    // Word index from byte address
    function automatic logic [7:0] word_idx(input logic [9:0] addr);
        return addr[9:2];
    endfunction

    // ============================================================
    // Write channel: address and data taken in either order
    assign wr_fire = aw_held_r && w_held_r && !S_AXI_BVALID;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            aw_idx_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            S_AXI_AWREADY <= !aw_held_r && !S_AXI_AWREADY;
            S_AXI_WREADY <= !w_held_r && !S_AXI_WREADY;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_r <= 1'b1;
                S_AXI_AWREADY <= 1'b0;
                aw_idx_r <= word_idx(S_AXI_AWADDR);
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_r <= 1'b1;
                S_AXI_WREADY <= 1'b0;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end
        end
    end

    // Write response, one cycle after both halves are held
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            // Status and receive data are read-only: writes are refused
            S_AXI_BRESP <= (aw_idx_r == IDX_CONTROL || aw_idx_r == IDX_TX_FILL
                || aw_idx_r == IDX_TX_DATA || aw_idx_r == IDX_INT_STATUS
                || aw_idx_r == IDX_INT_MASK) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // Control registers written from the bus, low byte only
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            tx_en_r <= RST_TX_EN;
            tx_fill_threshold_r <= RST_TX_FILL;
            int_mask_r <= RST_INT_MASK;
        end else if (wr_fire && wstrb_r[0]) begin
            if (aw_idx_r == IDX_CONTROL) begin
                tx_en_r <= wdata_r[BIT_CTRL_TX_EN];
            end
            if (aw_idx_r == IDX_TX_FILL) begin
                tx_fill_threshold_r <= wdata_r[7:0];
            end
            if (aw_idx_r == IDX_INT_MASK) begin
                int_mask_r <= wdata_r[IRQ_W-1:0];
            end
        end
    end

    // ============================================================
    // Read channel, answer one cycle after the address is taken
    assign ar_idx = word_idx(S_AXI_ARADDR);
    assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;

    // Read mux; reading the receive data word pops the queue
    always_comb begin
        rd_word = '0;
        rd_ok = 1'b1;
        unique case (ar_idx)
            IDX_CHANNEL_STATUS: rd_word[7:0] = status_word;
            IDX_CONTROL: rd_word[0] = tx_en_r;
            IDX_TX_FILL: rd_word[7:0] = tx_fill_threshold_r;
            IDX_RX_DATA: rd_word[7:0] = rx_head;
            IDX_INT_STATUS: rd_word[IRQ_W-1:0] = int_stat_r;
            IDX_INT_MASK: rd_word[IRQ_W-1:0] = int_mask_r;
            IDX_FILL_LEVELS: rd_word = {7'h00, tx_count, 7'h00, rx_count};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY && !rd_fire;
            if (rd_fire) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_word;
                S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ============================================================
    // Receive path: queue plus one held character in the shift register
    assign rx_pop = rd_fire && ar_idx == IDX_RX_DATA;
    // Held character goes in on the first read, into the slot just freed
    assign rx_push = hold_valid_r ? rx_pop
        : (RX_CHAR_VALID && (rx_count != QUEUE_FULL_CNT || rx_pop));
    assign rx_push_data = hold_valid_r ? hold_data_r : RX_CHAR_DATA;
    // A new arrival while holding overwrites the held one
    assign rx_lost = RX_CHAR_VALID && hold_valid_r && !rx_pop;

    // Shift-register hold, one extra character beyond a full queue
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            hold_valid_r <= 1'b0;
            hold_data_r <= '0;
        end else if (RX_CHAR_VALID
            && (hold_valid_r || (rx_count == QUEUE_FULL_CNT && !rx_pop))) begin
            hold_valid_r <= 1'b1;
            hold_data_r <= RX_CHAR_DATA;
        end else if (rx_pop) begin
            hold_valid_r <= 1'b0;
        end
    end

    ufs_queue u_rx_queue (
        .clk(REF_CLK),
        .rst(RST),
        .push(rx_push),
        .push_data(rx_push_data),
        .pop(rx_pop),
        .head(rx_head),
        .count(rx_count)
    );

    // Receive flags follow queue events, not direct writes
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rx_queue_full_flag_r <= 1'b0;
            rx_char_waiting_r <= 1'b0;
        end else begin
            if (rx_push && !rx_pop && rx_count == QUEUE_FULL_CNT - 9'h001) begin
                rx_queue_full_flag_r <= 1'b1;
            end else if (rx_pop && !rx_push) begin
                rx_queue_full_flag_r <= 1'b0;
            end
            if (rx_push) begin
                rx_char_waiting_r <= 1'b1;
            end else if (rx_pop && rx_count == 9'h001) begin
                rx_char_waiting_r <= 1'b0;
            end
        end
    end

    // ============================================================
    // Transmit path: serializer drains only while enabled
    assign tx_push = wr_fire && wstrb_r[0] && aw_idx_r == IDX_TX_DATA;
    assign tx_pop = TX_CHAR_TAKE && TX_CHAR_VALID && tx_en_r;
    assign tx_space_avail = tx_count != QUEUE_FULL_CNT
        && tx_count <= {1'b0, tx_fill_threshold_r};

    ufs_queue u_tx_queue (
        .clk(REF_CLK),
        .rst(RST),
        .push(tx_push),
        .push_data(wdata_r[7:0]),
        .pop(tx_pop),
        .head(tx_head),
        .count(tx_count)
    );

    // Serializer offer: nothing is presented while disabled
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            TX_CHAR_VALID <= 1'b0;
            TX_CHAR_DATA <= '0;
        end else begin
            TX_CHAR_VALID <= tx_en_r && tx_count != '0 && !tx_push && !tx_pop;
            TX_CHAR_DATA <= tx_head;
        end
    end

    // ============================================================
    // Status word and interrupt
    always_comb begin
        status_word = '0;
        status_word[BIT_TX_SPACE] = tx_space_avail;
        status_word[BIT_RX_FULL] = rx_queue_full_flag_r;
        status_word[BIT_RX_WAIT] = rx_char_waiting_r;
    end

    assign int_event = {rx_lost, tx_space_avail && !tx_space_prev_r,
        rx_queue_full_flag_r, rx_push};

    // Sticky events, write one to clear; a new event wins over the clear
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            int_stat_r <= '0;
            tx_space_prev_r <= 1'b0;
            CHANNEL_STATUS <= '0;
            IRQ <= 1'b0;
        end else begin
            tx_space_prev_r <= tx_space_avail;
            CHANNEL_STATUS <= status_word;
            IRQ <= |(int_stat_r & int_mask_r);
            if (wr_fire && wstrb_r[0] && aw_idx_r == IDX_INT_STATUS) begin
                int_stat_r <= (int_stat_r & ~wdata_r[IRQ_W-1:0]) | int_event;
            end else begin
                int_stat_r <= int_stat_r | int_event;
            end
        end
    end

    // ============================================================
    // Assertions
    sequence s_rx_read;
        rd_fire && ar_idx == IDX_RX_DATA;
    endsequence

    property p_tx_space_full;
        @(posedge REF_CLK) disable iff (RST)
        tx_count == QUEUE_FULL_CNT |-> !tx_space_avail;
    endproperty
    a_tx_space_full: assert property (p_tx_space_full) else $error("space flag while full");

    property p_tx_space_thr;
        @(posedge REF_CLK) disable iff (RST)
        (tx_count <= {1'b0, tx_fill_threshold_r} && tx_count < QUEUE_FULL_CNT)
            |-> tx_space_avail;
    endproperty
    a_tx_space_thr: assert property (p_tx_space_thr) else $error("space flag missing");

    property p_tx_disabled;
        @(posedge REF_CLK) disable iff (RST)
        !tx_en_r |=> !TX_CHAR_VALID;
    endproperty
    a_tx_disabled: assert property (p_tx_disabled) else $error("offer while disabled");

    property p_rx_full_set;
        @(posedge REF_CLK) disable iff (RST)
        rx_push && !rx_pop && rx_count == 9'h0ff |=> rx_queue_full_flag_r;
    endproperty
    a_rx_full_set: assert property (p_rx_full_set) else $error("full flag not set");

    property p_rx_full_clr;
        @(posedge REF_CLK) disable iff (RST)
        s_rx_read ##0 (!hold_valid_r && !RX_CHAR_VALID) |=> !rx_queue_full_flag_r;
    endproperty
    a_rx_full_clr: assert property (p_rx_full_clr) else $error("full flag not cleared");

    property p_rx_hold_read;
        @(posedge REF_CLK) disable iff (RST)
        s_rx_read ##0 (hold_valid_r && rx_queue_full_flag_r && !RX_CHAR_VALID)
            |=> rx_queue_full_flag_r && !hold_valid_r && rx_count == QUEUE_FULL_CNT;
    endproperty
    a_rx_hold_read: assert property (p_rx_hold_read) else $error("held char mishandled");

    property p_rx_wait_set;
        @(posedge REF_CLK) disable iff (RST)
        rx_push |=> rx_char_waiting_r ##1 CHANNEL_STATUS[BIT_RX_WAIT];
    endproperty
    a_rx_wait_set: assert property (p_rx_wait_set) else $error("waiting flag not set");

    property p_rx_wait_clr;
        @(posedge REF_CLK) disable iff (RST)
        $fell(rx_char_waiting_r) |-> $past(rx_count) == 9'h001 && rx_count == 9'h000;
    endproperty
    a_rx_wait_clr: assert property (p_rx_wait_clr) else $error("waiting flag dropped early");

    property p_rx_limit;
        @(posedge REF_CLK) disable iff (RST)
        hold_valid_r |-> rx_count == QUEUE_FULL_CNT;
    endproperty
    a_rx_limit: assert property (p_rx_limit) else $error("hold without full queue");

    property p_status_ro;
        @(posedge REF_CLK) disable iff (RST)
        wr_fire && aw_idx_r == IDX_CHANNEL_STATUS |=> S_AXI_BRESP == RESP_SLVERR;
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write accepted");
endmodule
`default_nettype wire

// file: shared/ufs_pkg.sv
// Package of constants and types for the UART status flag block
// ============================================================
`default_nettype none
package ufs_pkg;
    // ============================================================
    // Queue geometry
    localparam int QUEUE_DEPTH = 256;
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] QUEUE_FULL_CNT = 9'h100;
    // ============================================================
    // Register word indices (byte address = 4 * index)
    localparam logic [7:0] IDX_CHANNEL_STATUS = 8'h01;
    localparam logic [7:0] IDX_CONTROL = 8'h10;
    localparam logic [7:0] IDX_TX_FILL = 8'h11;
    localparam logic [7:0] IDX_TX_DATA = 8'h12;
    localparam logic [7:0] IDX_RX_DATA = 8'h13;
    localparam logic [7:0] IDX_INT_STATUS = 8'h14;
    localparam logic [7:0] IDX_INT_MASK = 8'h15;
    localparam logic [7:0] IDX_FILL_LEVELS = 8'h16;
    // ============================================================
    // Status field positions
    localparam int BIT_RX_WAIT = 0;
    localparam int BIT_RX_FULL = 1;
    localparam int BIT_TX_SPACE = 2;
    localparam int BIT_CTRL_TX_EN = 0;
    // Interrupt bits: 0 rx char arrived, 1 rx full, 2 tx space, 3 rx lost
    localparam int IRQ_W = 4;
    localparam int BIT_IRQ_LOST = 3;
    // ============================================================
    // Reset values
    localparam logic [7:0] RST_TX_FILL = 8'hff;
    localparam logic RST_TX_EN = 1'b0;
    localparam logic [IRQ_W-1:0] RST_INT_MASK = 4'h0;
    // ============================================================
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// file: logic/ufs_queue.sv
// Byte queue of 256 entries with occupancy count
`default_nettype none
module ufs_queue
    import ufs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic push,
    input wire logic [7:0] push_data,
    // Drain side
    input wire logic pop,
    output logic [7:0] head,
    // Occupancy
    output logic [CNT_W-1:0] count
);
    logic [7:0] mem [QUEUE_DEPTH];
    logic [7:0] wr_ptr_r;
    logic [7:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;
    logic do_push;
    logic do_pop;

    // Guards: no push when full unless a pop frees a slot, no pop when empty
    assign do_pop = pop && (count_r != '0);
    assign do_push = push && (count_r != QUEUE_FULL_CNT || do_pop);
    assign head = mem[rd_ptr_r];
    assign count = count_r;

    // Storage, no reset needed
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_r] <= push_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 8'h01;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 8'h01;
            end
            count_r <= count_r + CNT_W'(do_push) - CNT_W'(do_pop);
        end
    end
endmodule
`default_nettype wire

// file: bench/ufs_line_model.sv
// Line-side model: receive shift register and transmit serializer
`default_nettype none
module ufs_line_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Receive shift register side
    output logic rx_vld,
    output logic [7:0] rx_dat,
    // Serializer side
    input wire logic tx_vld,
    input wire logic [7:0] tx_dat,
    output logic tx_take,
    // Slow serializer takes one character every fourth cycle
    input wire logic slow
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] pace_r;
    logic [7:0] got[$];
    initial begin
        rx_vld = 1'b0;
        rx_dat = 8'h00;
        tx_take = 1'b0;
    end
    // ============================================================
    // Receive: one-cycle pulse; data line shows the inverse afterwards
    // so a late sample never sees a stale match
    task automatic send_char(input logic [7:0] c);
        @(posedge clk);
        rx_vld <= 1'b1;
        rx_dat <= c;
        @(posedge clk);
        rx_vld <= 1'b0;
        rx_dat <= ~c;
    endtask
    // ============================================================
    // Transmit: record at the take edge, never two takes back to back
    always @(posedge clk) begin
        if (rst) begin
            pace_r <= 2'd0;
            tx_take <= 1'b0;
        end else begin
            pace_r <= pace_r + 2'd1;
            tx_take <= tx_vld && !tx_take && (!slow || pace_r == 2'd3);
            if (tx_take && tx_vld) got.push_back(tx_dat);
        end
    end
endmodule
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the UART status flag block
`default_nettype none
module tb;
    import ufs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, rdata, d;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, rx_vld, tx_take, tx_vld, irq;
    logic slow = 1'b0;
    logic [1:0] bresp, rresp, r;
    logic [7:0] rx_dat, tx_dat, status;
    int mismatches = 0;
    int n_compared = 0;
    always #10 clk = ~clk;
    ufs_status ufs_status_inst (.REF_CLK(clk), .RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .RX_CHAR_VALID(rx_vld), .RX_CHAR_DATA(rx_dat), .TX_CHAR_TAKE(tx_take),
        .TX_CHAR_VALID(tx_vld), .TX_CHAR_DATA(tx_dat), .CHANNEL_STATUS(status), .IRQ(irq));
    ufs_line_model ufs_line_model_inst (.clk(clk), .rst(rst), .rx_vld(rx_vld), .rx_dat(rx_dat),
        .tx_vld(tx_vld), .tx_dat(tx_dat), .tx_take(tx_take), .slow(slow));
    // ============================================================
    // Comparisons
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t response %b expected %b", $time, g, e);
        end
    endtask
    // ============================================================
    // Bus cycles: payload held until each channel's own ready
    task automatic axi_wr(input logic [7:0] idx, input logic [31:0] v, output logic [1:0] rs);
        bit b;
        b = 1'b0;
        rs = 2'bxx;
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50 && !b; i++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                rs = bresp;
                bready <= 1'b0;
                b = 1'b1;
            end
        end
        if (!b) chk(32'h0, 32'h1);
    endtask
    task automatic axi_rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] rs);
        bit b;
        b = 1'b0;
        rs = 2'bxx;
        v = 'x;
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50 && !b; i++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                v = rdata;
                rs = rresp;
                rready <= 1'b0;
                b = 1'b1;
            end
        end
        if (!b) chk(32'h0, 32'h1);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        logic [1:0] rs;
        axi_wr(idx, v, rs);
        chk_resp(rs, RESP_OKAY);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] rs;
        axi_rd(idx, v, rs);
        chk_resp(rs, RESP_OKAY);
        chk(v, e);
    endtask
    // Bounded wait for the serializer to have taken n characters
    task automatic wait_tx(input int n);
        for (int i = 0; i < 3000 && ufs_line_model_inst.got.size() < n; i++) @(posedge clk);
        chk(32'(ufs_line_model_inst.got.size()), 32'(n));
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ============================================================
    // Watchdog: the whole run needs well under 10000 cycles
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end
    // ============================================================
    // Tests
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        // Reset values and idle flags
        rd_chk(IDX_CHANNEL_STATUS, 32'h4);
        rd_chk(IDX_CONTROL, 32'h0);
        rd_chk(IDX_TX_FILL, 32'hff);
        rd_chk(IDX_INT_MASK, 32'h0);
        $display("test reset values done");
        // Flags cannot be written; unmapped place refused
        axi_wr(IDX_CHANNEL_STATUS, 32'h0, r);
        chk_resp(r, RESP_SLVERR);
        rd_chk(IDX_CHANNEL_STATUS, 32'h4);
        axi_rd(8'h3f, d, r);
        chk_resp(r, RESP_SLVERR);
        $display("test read-only done");
        // Transmit queue loaded while disabled, threshold both sides of fill
        for (int i = 0; i < 3; i++) wr(IDX_TX_DATA, 32'h11 + i);
        repeat (20) @(posedge clk);
        chk(32'(ufs_line_model_inst.got.size()), 32'h0);
        wr(IDX_TX_FILL, 32'h2);
        rd_chk(IDX_CHANNEL_STATUS, 32'h0);
        wr(IDX_TX_FILL, 32'h3);
        rd_chk(IDX_CHANNEL_STATUS, 32'h4);
        slow <= 1'b1;
        wr(IDX_CONTROL, 32'h1);
        wait_tx(3);
        for (int i = 0; i < 3; i++) chk(ufs_line_model_inst.got[i], 32'h11 + i);
        // Full transmit queue at the widest threshold
        wr(IDX_CONTROL, 32'h0);
        wr(IDX_TX_FILL, 32'hff);
        ufs_line_model_inst.got.delete();
        for (int i = 0; i < 255; i++) wr(IDX_TX_DATA, 32'(i));
        rd_chk(IDX_CHANNEL_STATUS, 32'h4);
        wr(IDX_TX_DATA, 32'hff);
        rd_chk(IDX_CHANNEL_STATUS, 32'h0);
        slow <= 1'b0;
        wr(IDX_CONTROL, 32'h1);
        wait_tx(256);
        chk(ufs_line_model_inst.got[255], 32'hff);
        rd_chk(IDX_CHANNEL_STATUS, 32'h4);
        $display("test transmit done");
        // One character: waiting flag, interrupt raised, cleared, masked
        wr(IDX_CONTROL, 32'h0);
        wr(IDX_INT_STATUS, 32'hf);
        wr(IDX_INT_MASK, 32'h1);
        ufs_line_model_inst.send_char(8'ha5);
        rd_chk(IDX_CHANNEL_STATUS, 32'h5);
        chk({31'h0, irq}, 32'h1);
        rd_chk(IDX_INT_STATUS, 32'h1);
        wr(IDX_INT_STATUS, 32'h1);
        rd_chk(IDX_INT_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(IDX_INT_MASK, 32'h0);
        rd_chk(IDX_RX_DATA, 32'ha5);
        rd_chk(IDX_CHANNEL_STATUS, 32'h4);
        // Fill receive queue, one held, one more overwrites the held one
        for (int i = 0; i < 256; i++) begin
            ufs_line_model_inst.send_char(8'(i));
            if (i == 254) rd_chk(IDX_CHANNEL_STATUS, 32'h5);
        end
        rd_chk(IDX_CHANNEL_STATUS, 32'h7);
        rd_chk(IDX_FILL_LEVELS, 32'h100);
        chk({31'h0, irq}, 32'h0);
        ufs_line_model_inst.send_char(8'hee);
        ufs_line_model_inst.send_char(8'hdd);
        axi_rd(IDX_INT_STATUS, d, r);
        chk(d & 32'h8, 32'h8);
        rd_chk(IDX_RX_DATA, 32'h0);
        rd_chk(IDX_CHANNEL_STATUS, 32'h7);
        rd_chk(IDX_RX_DATA, 32'h1);
        rd_chk(IDX_CHANNEL_STATUS, 32'h5);
        for (int i = 2; i < 256; i++) rd_chk(IDX_RX_DATA, 32'(i));
        rd_chk(IDX_CHANNEL_STATUS, 32'h5);
        rd_chk(IDX_RX_DATA, 32'hdd);
        rd_chk(IDX_CHANNEL_STATUS, 32'h4);
        chk({24'h0, status}, 32'h4);
        $display("test receive done");
        test_done();
    end
endmodule
`default_nettype wire
